// ---- dv/ctc_host_model.sv ----
`timescale 1ns/1ps
module ctc_host_model
  import ctc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = CTC_DEV_ADDR_DFLT
) (
  input wire logic i_sys_clk,
  input wire logic i_sda_wire,
  output logic o_scl,
  output logic o_sda_low
);
  int unsigned nacks;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    nacks = 0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // bit timing
  // Data moves mid-low so setup and hold both exceed the device filter lag
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    wt(8);
    o_scl = 1'b1;
    wt(6);
    r = i_sda_wire;
    wt(6);
    o_scl = 1'b0;
    wt(8);
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    wt(8);
    o_scl = 1'b1;
    wt(8);
    o_sda_low = 1'b1;
    wt(8);
    o_scl = 1'b0;
    wt(8);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    wt(8);
    o_scl = 1'b1;
    wt(8);
    o_sda_low = 1'b0;
    wt(12);
  endtask
  task automatic byte_out(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nacks++;
  endtask
  task automatic byte_in(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(last, r);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(ptr);
    byte_out(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(ptr);
    start();
    byte_out({DEV_ADDR, 1'b1});
    byte_in(1'b1, d);
    stop();
  endtask
  // two-byte burst, pointer steps after each byte
  task automatic wr2(input logic [7:0] ptr, input logic [15:0] d);
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(ptr);
    byte_out(d[15:8]);
    byte_out(d[7:0]);
    stop();
  endtask
  task automatic rd2(input logic [7:0] ptr, output logic [15:0] d);
    logic [7:0] hi;
    logic [7:0] lo;
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(ptr);
    start();
    byte_out({DEV_ADDR, 1'b1});
    byte_in(1'b0, hi);
    byte_in(1'b1, lo);
    stop();
    d = {hi, lo};
  endtask
  // transfer meant for another device, expect two refusals
  task automatic wr_other(input logic [7:0] d);
    start();
    byte_out({DEV_ADDR ^ 7'h01, 1'b0});
    byte_out(d);
    stop();
  endtask
endmodule // ctc_host_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import ctc_pkg::*;
  logic i_sys_clk, i_rst, scl, sda_low, sda_wire, sda_o, sda_oe;
  logic [6:0] ctl;
  logic [15:0] programmed_charge_current, thr;
  ctc_src_t src;
  logic system_enable_output, iso_off;
  logic [7:0] rdat;
  logic [15:0] rd16;
  int fails, total_checks;
  logic [15:0] code_thr [8] = '{16'h007D, 16'h0145, 16'h020D, 16'h02D5,
    16'h039D, 16'h0497, 16'h0591, 16'h06A4};
  // Ratio cases: cfg, charge current, threshold, source
  logic [41:0] rcase [6] = '{{8'h1C, 16'h0FA0, 16'h00C8, 2'h1},
    {8'hEC, 16'h0FA0, 16'h0190, 2'h2}, {8'h04, 16'h0FA0, 16'h0320, 2'h3},
    {8'h04, 16'h4E20, 16'h06A4, 2'h3}, {8'h10, 16'h0064, 16'h007D, 2'h1},
    {8'h08, 16'h0FAF, 16'h0191, 2'h2}};
  // Mode cases: mode, ldo/rail/node/weak/chg/vin0/bmon, enable, isolation
  logic [10:0] mcase [11] = '{{2'h0, 7'h60, 2'h2}, {2'h0, 7'h40, 2'h0},
    {2'h1, 7'h10, 2'h2}, {2'h1, 7'h60, 2'h0}, {2'h2, 7'h03, 2'h3},
    {2'h2, 7'h0B, 2'h0}, {2'h2, 7'h62, 2'h2}, {2'h2, 7'h01, 2'h0},
    {2'h3, 7'h40, 2'h2}, {2'h3, 7'h0C, 2'h2}, {2'h3, 7'h44, 2'h0}};
  // Open-drain data line with pull-up
  assign sda_wire = ~((sda_oe & ~sda_o) | sda_low);
  ctc_term_cfg uut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_wire),
    .o_sda(sda_o), .o_sda_oe(sda_oe), .i_ldo_active(ctl[6]),
    .i_sys_voltage_ok(ctl[5]), .i_battery_node_ok(ctl[4]),
    .i_battery_above_weak(ctl[3]), .i_charge_enable(ctl[2]),
    .i_charger_input_zero(ctl[1]), .i_battery_monitor_enable(ctl[0]),
    .i_programmed_charge_current(programmed_charge_current), .o_term_threshold(thr),
    .o_term_source(src), .o_system_enable_output(system_enable_output),
    .o_isolation_off(iso_off)
  );
  ctc_host_model host (
    .i_sys_clk(i_sys_clk), .i_sda_wire(sda_wire), .o_scl(scl),
    .o_sda_low(sda_low)
  );
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic final_report();
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Inputs pass a sync chain, so settle before sampling
  task automatic drive(input logic [6:0] c, input logic [15:0] i);
    @(negedge i_sys_clk);
    ctl = c;
    programmed_charge_current = i;
    repeat (8) @(negedge i_sys_clk);
  endtask
  initial begin
    repeat (90000) @(posedge i_sys_clk);
    fails++;
    final_report();
  end
  initial begin
    fails = 0;
    total_checks = 0;
    i_rst = 1'b1;
    ctl = 7'h00;
    programmed_charge_current = 16'h0000;
    repeat (6) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    check(thr, 16'h007D);
    check({14'h0, src}, {14'h0, CTC_SRC_CODE});
    check({14'h0, system_enable_output, iso_off}, 16'h0000);
    host.rd(CTC_REG_TERM_CFG, rdat);
    check({8'h00, rdat}, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      host.wr(CTC_REG_TERM_CFG, {c[2:0], 5'h00});
      check(thr, code_thr[c]);
      host.rd(CTC_REG_TERM_CFG, rdat);
      check({8'h00, rdat}, {8'h00, c[2:0], 5'h00});
    end
    for (int k = 0; k < 6; k++) begin
      drive(7'h00, rcase[k][33:18]);
      host.wr(CTC_REG_TERM_CFG, rcase[k][41:34]);
      check(thr, rcase[k][17:2]);
      check({14'h0, src}, {14'h0, rcase[k][1:0]});
      host.rd(CTC_REG_TERM_CFG, rdat);
      check({8'h00, rdat}, {8'h00, rcase[k][41:34]});
    end
    // Unmapped pointer and foreign address leave the register alone
    host.wr(8'h12, 8'h5A);
    host.wr_other(8'h11);
    host.rd(8'h12, rdat);
    check({8'h00, rdat}, 16'h0000);
    host.rd(CTC_REG_TERM_CFG, rdat);
    check({8'h00, rdat}, 16'h0008);
    check(host.nacks[15:0], 16'h0002);
    // Bursts step the pointer across the register
    host.wr2(8'h10, 16'h5A6D);
    host.rd2(CTC_REG_TERM_CFG, rd16);
    check(rd16, 16'h6D00);
    for (int k = 0; k < 11; k++) begin
      host.wr(CTC_REG_TERM_CFG, {6'h00, mcase[k][10:9]});
      drive(mcase[k][8:2], 16'h0FA0);
      check(16'(system_enable_output), 16'(mcase[k][1]));
      check(16'(iso_off), 16'(mcase[k][0]));
    end
    check(host.nacks[15:0], 16'h0002);
    // Mid-run reset brings every field back to its default
    @(negedge i_sys_clk);
    i_rst = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    check({14'h0, system_enable_output, iso_off}, 16'h0000);
    check(thr, 16'h007D);
    host.rd(CTC_REG_TERM_CFG, rdat);
    check({8'h00, rdat}, 16'h0000);
    final_report();
  end
endmodule // testbench

// ---- include/ctc_pkg.sv ----
package ctc_pkg;

  // Configuration register and its fields
  localparam logic [7:0] CTC_REG_TERM_CFG = 8'h11;
  localparam int CTC_CODE_MSB = 7;
  localparam int CTC_CODE_LSB = 5;
  localparam int CTC_BIT_DIV20 = 4;
  localparam int CTC_BIT_DIV10 = 3;
  localparam int CTC_BIT_DIV5 = 2;
  localparam int CTC_MODE_MSB = 1;
  localparam int CTC_MODE_LSB = 0;
  localparam logic [2:0] CTC_CODE_RST = 3'h0;
  localparam logic [1:0] CTC_MODE_RST = 2'h0;
  localparam logic [7:0] CTC_READ_UNMAPPED = 8'h00;

  // System-enable modes
  localparam logic [1:0] CTC_MODE_REG = 2'h0;
  localparam logic [1:0] CTC_MODE_BNODE = 2'h1;
  localparam logic [1:0] CTC_MODE_WEAK_ISO = 2'h2;
  localparam logic [1:0] CTC_MODE_CHG_WEAK = 2'h3;

  // Currents in units of 0.1 mA, then the unitless ratio divisors
  localparam logic [15:0] CTC_TERM_MIN = 16'h007D;
  localparam logic [15:0] CTC_TERM_MAX = 16'h06A4;
  localparam logic [15:0] CTC_DIV20 = 16'h0014;
  localparam logic [15:0] CTC_DIV10 = 16'h000A;
  localparam logic [15:0] CTC_DIV5 = 16'h0005;

  // Serial port
  localparam logic [6:0] CTC_DEV_ADDR_DFLT = 7'h14;
  localparam logic [3:0] CTC_BITS_PER_BYTE = 4'h8;

  // Synchronised inputs
  localparam int CTC_NSYNC = 9;
  localparam int CTC_IN_SCL = 0;
  localparam int CTC_IN_SDA = 1;
  localparam int CTC_IN_LDO = 2;
  localparam int CTC_IN_SYSOK = 3;
  localparam int CTC_IN_BNODE = 4;
  localparam int CTC_IN_BWEAK = 5;
  localparam int CTC_IN_CHGEN = 6;
  localparam int CTC_IN_VIN0 = 7;
  localparam int CTC_IN_BMON = 8;
  localparam logic [CTC_NSYNC-1:0] CTC_SYNC_RST = 9'h003;

  typedef enum logic [1:0] {
    CTC_SRC_CODE, CTC_SRC_DIV20, CTC_SRC_DIV10, CTC_SRC_DIV5
  } ctc_src_t;

  function automatic logic [15:0] ctc_code_to_dma(input logic [2:0] code);
    case (code)
      3'h0: ctc_code_to_dma = 16'h007D;
      3'h1: ctc_code_to_dma = 16'h0145;
      3'h2: ctc_code_to_dma = 16'h020D;
      3'h3: ctc_code_to_dma = 16'h02D5;
      3'h4: ctc_code_to_dma = 16'h039D;
      3'h5: ctc_code_to_dma = 16'h0497;
      3'h6: ctc_code_to_dma = 16'h0591;
      default: ctc_code_to_dma = 16'h06A4;
    endcase
  endfunction

  function automatic logic [15:0] ctc_clamp(input logic [15:0] v);
    if (v < CTC_TERM_MIN) ctc_clamp = CTC_TERM_MIN;
    else if (v > CTC_TERM_MAX) ctc_clamp = CTC_TERM_MAX;
    else ctc_clamp = v;
  endfunction

endpackage

// ---- include/ctc_term_if.sv ----
`timescale 1ns/1ps
interface ctc_term_if;
  import ctc_pkg::*;
  logic clk;
  logic rst;
  logic [2:0] code;
  logic div20;
  logic div10;
  logic div5;
  logic [15:0] programmed_charge_current;
  logic [15:0] thr;
  ctc_src_t src;
  modport cfg (output clk, rst, code, div20, div10, div5, programmed_charge_current,
               input thr, src);
  modport calc (input clk, rst, code, div20, div10, div5, programmed_charge_current,
                output thr, src);
endinterface

// ---- logic/ctc_term_calc.sv ----
`timescale 1ns/1ps
module ctc_term_calc
  import ctc_pkg::*;
(
  ctc_term_if.calc ifc
);

  // Ratio priority and clamp
  always_comb begin
    if (ifc.div20) begin
      ifc.thr = ctc_clamp(ifc.programmed_charge_current / CTC_DIV20);
      ifc.src = CTC_SRC_DIV20;
    end else if (ifc.div10) begin
      ifc.thr = ctc_clamp(ifc.programmed_charge_current / CTC_DIV10);
      ifc.src = CTC_SRC_DIV10;
    end else if (ifc.div5) begin
      ifc.thr = ctc_clamp(ifc.programmed_charge_current / CTC_DIV5);
      ifc.src = CTC_SRC_DIV5;
    end else begin
      ifc.thr = ctc_code_to_dma(ifc.code);
      ifc.src = CTC_SRC_CODE;
    end
  end

  property p_code_table;
    @(posedge ifc.clk) disable iff (ifc.rst)
    !(ifc.div20 || ifc.div10 || ifc.div5) |->
      ifc.thr == ctc_code_to_dma(ifc.code) && ifc.src == CTC_SRC_CODE;
  endproperty
  a_code_table: assert property (p_code_table)
    else $error("fixed code threshold wrong");

  property p_div20;
    @(posedge ifc.clk) disable iff (ifc.rst)
    ifc.div20 |-> ifc.src == CTC_SRC_DIV20 &&
      ifc.thr == ctc_clamp(ifc.programmed_charge_current / CTC_DIV20);
  endproperty
  a_div20: assert property (p_div20)
    else $error("one-twentieth ratio not applied");

  property p_div10;
    @(posedge ifc.clk) disable iff (ifc.rst)
    !ifc.div20 && ifc.div10 |-> ifc.src == CTC_SRC_DIV10 &&
      ifc.thr == ctc_clamp(ifc.programmed_charge_current / CTC_DIV10);
  endproperty
  a_div10: assert property (p_div10)
    else $error("one-tenth ratio not applied");

  property p_div5;
    @(posedge ifc.clk) disable iff (ifc.rst)
    !ifc.div20 && !ifc.div10 && ifc.div5 |-> ifc.src == CTC_SRC_DIV5 &&
      ifc.thr == ctc_clamp(ifc.programmed_charge_current / CTC_DIV5);
  endproperty
  a_div5: assert property (p_div5)
    else $error("one-fifth ratio not applied");

  property p_clamp;
    @(posedge ifc.clk) disable iff (ifc.rst)
    ifc.src != CTC_SRC_CODE |->
      ifc.thr >= CTC_TERM_MIN && ifc.thr <= CTC_TERM_MAX;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("ratio threshold outside limits");

endmodule // ctc_term_calc

// ---- logic/ctc_term_cfg.sv ----
`timescale 1ns/1ps
module ctc_term_cfg
  import ctc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = CTC_DEV_ADDR_DFLT,
  parameter logic [2:0] CODE_RST = CTC_CODE_RST
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_ldo_active,
  input wire logic i_sys_voltage_ok,
  input wire logic i_battery_node_ok,
  input wire logic i_battery_above_weak,
  input wire logic i_charge_enable,
  input wire logic i_charger_input_zero,
  input wire logic i_battery_monitor_enable,
  input wire logic [15:0] i_programmed_charge_current,
  output logic [15:0] o_term_threshold,
  output ctc_src_t o_term_source,
  output logic o_system_enable_output,
  output logic o_isolation_off
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WR_ACK, ST_RDATA, ST_RD_MACK
  } ctc_i2c_st_t;

  logic [CTC_NSYNC-1:0] raw;
  logic [CTC_NSYNC-1:0] s1_q;
  logic [CTC_NSYNC-1:0] s2_q;
  logic [CTC_NSYNC-1:0] s3_q;
  logic [CTC_NSYNC-1:0] flt_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  ctc_i2c_st_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic mack_q;
  logic wr_fire;
  logic [7:0] cfg_q;
  logic [1:0] mode;
  logic iso_cond;
  logic system_enable_output_d;
  logic iso_off_d;
  ctc_term_if ifc ();

  function automatic logic [7:0] ctc_read_mux(input logic [7:0] ptr,
                                               input logic [7:0] cfg);
    ctc_read_mux = (ptr == CTC_REG_TERM_CFG) ? cfg : CTC_READ_UNMAPPED;
  endfunction

  assign raw[CTC_IN_SCL] = i_scl;
  assign raw[CTC_IN_SDA] = i_sda;
  assign raw[CTC_IN_LDO] = i_ldo_active;
  assign raw[CTC_IN_SYSOK] = i_sys_voltage_ok;
  assign raw[CTC_IN_BNODE] = i_battery_node_ok;
  assign raw[CTC_IN_BWEAK] = i_battery_above_weak;
  assign raw[CTC_IN_CHGEN] = i_charge_enable;
  assign raw[CTC_IN_VIN0] = i_charger_input_zero;
  assign raw[CTC_IN_BMON] = i_battery_monitor_enable;

  // Three stages, value taken once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < CTC_NSYNC; gi++) begin : g_sync
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          s1_q[gi] <= CTC_SYNC_RST[gi];
          s2_q[gi] <= CTC_SYNC_RST[gi];
          s3_q[gi] <= CTC_SYNC_RST[gi];
          flt_q[gi] <= CTC_SYNC_RST[gi];
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= flt_q[CTC_IN_SCL];
      sda_prev_q <= flt_q[CTC_IN_SDA];
    end
  end

  assign scl_rise = flt_q[CTC_IN_SCL] & ~scl_prev_q;
  assign scl_fall = ~flt_q[CTC_IN_SCL] & scl_prev_q;
  assign start_c = flt_q[CTC_IN_SCL] & scl_prev_q & sda_prev_q &
                   ~flt_q[CTC_IN_SDA];
  assign stop_c = flt_q[CTC_IN_SCL] & scl_prev_q & ~sda_prev_q &
                  flt_q[CTC_IN_SDA];

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (start_c) begin
      state_q <= ST_DEV;
      cnt_q <= 4'h0;
    end else if (stop_c) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_DEV, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], flt_q[CTC_IN_SDA]};
            cnt_q <= 4'(cnt_q + 4'h1);
          end else if (scl_fall && cnt_q == CTC_BITS_PER_BYTE) begin
            cnt_q <= 4'h0;
            if (state_q == ST_DEV) begin
              rw_q <= shift_q[0];
              state_q <= (shift_q[7:1] == DEV_ADDR) ? ST_DEV_ACK : ST_IDLE;
            end else if (state_q == ST_PTR) begin
              ptr_q <= shift_q;
              state_q <= ST_PTR_ACK;
            end else begin
              ptr_q <= 8'(ptr_q + 8'h01);
              state_q <= ST_WR_ACK;
            end
          end
        end
        ST_DEV_ACK: begin
          if (scl_fall) begin
            tx_q <= ctc_read_mux(ptr_q, cfg_q);
            state_q <= rw_q ? ST_RDATA : ST_PTR;
          end
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            state_q <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_q <= 4'(cnt_q + 4'h1);
          end else if (scl_fall) begin
            if (cnt_q == CTC_BITS_PER_BYTE) begin
              cnt_q <= 4'h0;
              ptr_q <= 8'(ptr_q + 8'h01);
              state_q <= ST_RD_MACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        end
        ST_RD_MACK: begin
          if (scl_rise) begin
            mack_q <= ~flt_q[CTC_IN_SDA];
          end else if (scl_fall) begin
            tx_q <= ctc_read_mux(ptr_q, cfg_q);
            state_q <= mack_q ? ST_RDATA : ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Open-drain data: only ever pulls low
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_sda <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_sda <= 1'b0;
      o_sda_oe <= (state_q == ST_DEV_ACK) || (state_q == ST_PTR_ACK) ||
                  (state_q == ST_WR_ACK) ||
                  ((state_q == ST_RDATA) && !tx_q[7]);
    end
  end

  assign wr_fire = (state_q == ST_WDATA) && !start_c && !stop_c &&
                   !scl_rise && scl_fall && (cnt_q == CTC_BITS_PER_BYTE) &&
                   (ptr_q == CTC_REG_TERM_CFG);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cfg_q <= {CODE_RST, 3'h0, CTC_MODE_RST};
    end else if (wr_fire) begin
      cfg_q <= shift_q;
    end
  end

  assign ifc.clk = i_sys_clk;
  assign ifc.rst = i_rst;
  assign ifc.code = cfg_q[CTC_CODE_MSB:CTC_CODE_LSB];
  assign ifc.div20 = cfg_q[CTC_BIT_DIV20];
  assign ifc.div10 = cfg_q[CTC_BIT_DIV10];
  assign ifc.div5 = cfg_q[CTC_BIT_DIV5];
  assign ifc.programmed_charge_current = i_programmed_charge_current;

  ctc_term_calc u_calc (
    .ifc (ifc.calc)
  );

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_term_threshold <= CTC_TERM_MIN;
      o_term_source <= CTC_SRC_CODE;
    end else begin
      o_term_threshold <= ifc.thr;
      o_term_source <= ifc.src;
    end
  end

  assign mode = cfg_q[CTC_MODE_MSB:CTC_MODE_LSB];
  assign iso_cond = flt_q[CTC_IN_VIN0] & flt_q[CTC_IN_BMON];

  always_comb begin
    system_enable_output_d = flt_q[CTC_IN_LDO] & flt_q[CTC_IN_SYSOK];
    iso_off_d = 1'b0;
    case (mode)
      CTC_MODE_REG: system_enable_output_d = flt_q[CTC_IN_LDO] & flt_q[CTC_IN_SYSOK];
      CTC_MODE_BNODE: system_enable_output_d = flt_q[CTC_IN_BNODE];
      CTC_MODE_WEAK_ISO: begin
        if (iso_cond && !flt_q[CTC_IN_BWEAK]) begin
          system_enable_output_d = 1'b1;
          iso_off_d = 1'b1;
        end
      end
      CTC_MODE_CHG_WEAK: system_enable_output_d = flt_q[CTC_IN_CHGEN] ?
                                    flt_q[CTC_IN_BWEAK] : flt_q[CTC_IN_LDO];
      default: system_enable_output_d = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_system_enable_output <= 1'b0;
      o_isolation_off <= 1'b0;
    end else begin
      o_system_enable_output <= system_enable_output_d;
      o_isolation_off <= iso_off_d;
    end
  end

  property p_mode_reg;
    @(posedge i_sys_clk) disable iff (i_rst)
    mode == CTC_MODE_REG |=>
      o_system_enable_output == $past(flt_q[CTC_IN_LDO] &
                                      flt_q[CTC_IN_SYSOK]);
  endproperty
  a_mode_reg: assert property (p_mode_reg)
    else $error("mode 00 enable wrong");

  property p_mode_bnode;
    @(posedge i_sys_clk) disable iff (i_rst)
    mode == CTC_MODE_BNODE |=> o_system_enable_output ==
      $past(flt_q[CTC_IN_BNODE]) && !o_isolation_off;
  endproperty
  a_mode_bnode: assert property (p_mode_bnode)
    else $error("mode 01 enable wrong");

  property p_weak_iso;
    @(posedge i_sys_clk) disable iff (i_rst)
    mode == CTC_MODE_WEAK_ISO && iso_cond && !flt_q[CTC_IN_BWEAK] |=>
      o_system_enable_output && o_isolation_off;
  endproperty
  a_weak_iso: assert property (p_weak_iso)
    else $error("weak battery isolation missing");

  property p_mode_chg;
    @(posedge i_sys_clk) disable iff (i_rst)
    mode == CTC_MODE_CHG_WEAK && flt_q[CTC_IN_CHGEN] |=>
      o_system_enable_output == $past(flt_q[CTC_IN_BWEAK]);
  endproperty
  a_mode_chg: assert property (p_mode_chg)
    else $error("mode 11 charging enable wrong");

  property p_iso_gate;
    @(posedge i_sys_clk) disable iff (i_rst)
    !iso_cond || mode != CTC_MODE_WEAK_ISO |=> !o_isolation_off;
  endproperty
  a_iso_gate: assert property (p_iso_gate)
    else $error("isolation off without qualifier");

  property p_addr_ack;
    @(posedge i_sys_clk) disable iff (i_rst)
    state_q == ST_DEV && scl_fall && cnt_q == CTC_BITS_PER_BYTE &&
      shift_q[7:1] == DEV_ADDR && !start_c && !stop_c |=> ##1 o_sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_write_apply;
    @(posedge i_sys_clk) disable iff (i_rst)
    wr_fire |=> cfg_q == $past(shift_q) ##1
      o_term_source == ifc.src && o_term_threshold == ifc.thr;
  endproperty
  a_write_apply: assert property (p_write_apply)
    else $error("written setting not applied");

  c_write: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_fire);
  c_read: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    state_q == ST_RDATA && ptr_q == CTC_REG_TERM_CFG);
  c_iso: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    o_isolation_off);

endmodule // ctc_term_cfg
